// ==== verilog/lfws_cmd_top.sv ====
// Summary of operation
// RULE1 - memory write command has select low, pixel bytes high; bytes latch on strobe rise
// RULE2 - accepting memory write reloads column and page counters to their start values
// RULE3 - start column and page follow the access control orientation bits
// RULE4 - each 18-bit pixel is stored at the counters, then counters advance
// RULE5 - any other command byte ends the memory write at once
// RULE6 - memory write leaves display, scroll, partial and sleep state untouched
// RULE7 - frame memory is never cleared by reset
// RULE8 - partial area takes four bytes: start high, start low, end high, end low
// RULE9 - partial rows are memory line pointers, not panel lines; partialHit here compares them with refreshLine, before the scroll mapping
// RULE10 - equal partial start and end rows give a one-row area
// RULE11 - partial start resets to 0, end to 127 or 159 per geometry
// RULE12 - scroll definition takes top fixed, scroll height, bottom fixed, high byte first
// RULE13 - refresh bit clear: top fixed counted from top, scroll follows it
// RULE14 - refresh bit set: top fixed counted from bottom, roles swap
// RULE15 - scroll height counts memory lines from the scroll start address
// RULE16 - host keeps the three scroll counts summing to the geometry's lines
// RULE17 - host keeps row/column swap clear while scrolling
// RULE18 - top fixed resets to 0 and scroll height to 160
// RULE19 - normal mode on or partial mode on leaves scroll mode
// RULE20 - host sets the memory window before entering scroll mode
// RULE21 - memory write uses the latest window start and end values
// RULE22 - geometry 01 selects 128 lines, 11 selects 160 lines
// RULE23 - pixels outside the geometry's column or row range are dropped
// RULE24 - column wraps to start and bumps page; page wraps to start
// RULE25 - end row below start row wraps partial area through last line
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "lfws_map.svh"
module lfws_cmd_top
   import lfws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic data_command_select,
   input wire logic write_strobe_n,
   input wire logic [7:0] hostData,
   input wire logic [7:0] refreshLine,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic memWrEn,
   output logic [6:0] memColumn,
   output logic [7:0] memRow,
   output logic [17:0] memPixel,
   output logic [7:0] scrollLine,
   output logic partialHit,
   output logic scrollMode
);
   function automatic logic [15:0] step(input logic [15:0] v, input logic down);
      step = down ? 16'(v - 16'h0001) : 16'(v + 16'h0001);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   logic byteValid;
   logic byteIsCmd;
   logic [7:0] byteData;
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   lfws_state_t state;
   logic [2:0] paramIdx;
   logic [7:0] paramHi;
   logic [1:0] pixPhase;
   logic [5:0] pixR;
   logic [5:0] pixG;
   logic [15:0] colCnt;
   logic [15:0] pageCnt;
   logic [7:0] memory_access_control;
   logic [1:0] geom;
   logic [15:0] sc;
   logic [15:0] ec;
   logic [15:0] sp;
   logic [15:0] ep;
   logic [15:0] ssa;
   logic [15:0] sr;
   logic [15:0] er;
   logic [15:0] top_fixed_lines;
   logic [15:0] scroll_region_lines;
   logic [15:0] bfa;

   lfws_byte_capture u_capture (
      .clk(clk),
      .rst_b(rst_b),
      .data_command_select(data_command_select),
      .write_strobe_n(write_strobe_n),
      .busData(hostData),
      .byteValid(byteValid),
      .byteIsCmd(byteIsCmd),
      .byteData(byteData)
   );

   // command decode
   wire cmdIn = byteValid & byteIsCmd;
   wire parIn = byteValid & ~byteIsCmd;
   wire isWrCmd = cmdIn && byteData == `LFWS_CMD_MEMWR;
   wire isModeOn = cmdIn &&
      (byteData == `LFWS_CMD_NORMAL_ON || byteData == `LFWS_CMD_PARTIAL_ON);
   wire lowParam = paramIdx[0];
   wire [15:0] paramWord = {paramHi, byteData};
   lfws_state_t next_state;
   assign next_state = isWrCmd ? LFWS_MEMWR :
      byteData == `LFWS_CMD_PARTIAL ? LFWS_PART :
      byteData == `LFWS_CMD_SCROLLDEF ? LFWS_SCRDEF : LFWS_IDLE;

   // orientation: mirrored axes run the counters downward from the end
   wire my = memory_access_control[`LFWS_MY_BIT];
   wire mx = memory_access_control[`LFWS_MX_BIT];
   wire mv = memory_access_control[`LFWS_MV_BIT];
   wire ml = memory_access_control[`LFWS_ML_BIT];
   wire [15:0] colFirst = mx ? ec : sc; // see RULE3
   wire [15:0] colLast = mx ? sc : ec;
   wire [15:0] pageFirst = my ? ep : sp; // see RULE3
   wire [15:0] pageLast = my ? sp : ep;

   // pixel path, three bytes per 18-bit word, upper six bits of each
   wire pixelDone = state == LFWS_MEMWR && parIn && pixPhase == 2'd2;
   wire [17:0] pixelWord = {pixR, pixG, byteData[7:2]};
   wire [15:0] physCol = mv ? pageCnt : colCnt;
   wire [15:0] physRow = mv ? colCnt : pageCnt;
   wire [15:0] maxRow = geom == `LFWS_GEOM_128 ? `LFWS_MAX_ROW_128 : `LFWS_MAX_ROW_160;
   wire inRange = physCol <= `LFWS_MAX_COL && physRow <= maxRow; // see RULE22
   wire colWrap = colCnt == colLast;
   wire [15:0] next_col = colWrap ? colFirst : step(colCnt, mx); // see RULE24
   wire [15:0] next_page = !colWrap ? pageCnt :
      pageCnt == pageLast ? pageFirst : step(pageCnt, my); // see RULE24

   // reset clears the strobe, column, row and pixel outputs of the memory port; contents are never cleared
   always_ff @(posedge clk) begin // see RULE7
      if (!rst_b) begin
         memWrEn <= 1'b0;
         memColumn <= 7'h00;
         memRow <= 8'h00;
         memPixel <= 18'h0_0000;
      end else begin
         memWrEn <= pixelDone && inRange; // see RULE23
         if (pixelDone) begin
            memColumn <= physCol[6:0]; // see RULE4
            memRow <= physRow[7:0];
            memPixel <= pixelWord;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         colCnt <= `LFWS_WIN_START_RST;
         pageCnt <= `LFWS_WIN_START_RST;
         pixPhase <= 2'd0;
         pixR <= 6'h00;
         pixG <= 6'h00;
      end else if (isWrCmd) begin
         colCnt <= colFirst; // see RULE2
         pageCnt <= pageFirst; // see RULE21
         pixPhase <= 2'd0;
      end else if (state == LFWS_MEMWR && parIn) begin
         pixPhase <= pixPhase == 2'd2 ? 2'd0 : 2'(pixPhase + 2'd1);
         if (pixPhase == 2'd0) begin
            pixR <= byteData[7:2];
         end
         if (pixPhase == 2'd1) begin
            pixG <= byteData[7:2];
         end
         if (pixelDone) begin
            colCnt <= next_col; // see RULE4
            pageCnt <= next_page;
         end
      end
   end

   // any command byte restarts parsing; a stray byte after the last parameter is ignored
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         state <= LFWS_IDLE;
         paramIdx <= 3'd0;
         paramHi <= 8'h00;
      end else if (cmdIn) begin
         state <= next_state; // see RULE5
         paramIdx <= 3'd0;
      end else if (parIn && state != LFWS_MEMWR && state != LFWS_IDLE) begin
         paramIdx <= 3'(paramIdx + 3'd1);
         if (!lowParam) begin
            paramHi <= byteData;
         end
         if ((state == LFWS_PART && paramIdx == 3'd3) ||
             (state == LFWS_SCRDEF && paramIdx == 3'd5)) begin
            state <= LFWS_IDLE;
         end
      end
   end

   // parameter words land on their low byte
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sr <= `LFWS_SR_RST; // see RULE11
         er <= (`LFWS_GEOM_RST == `LFWS_GEOM_128) ? `LFWS_MAX_ROW_128 : `LFWS_MAX_ROW_160;
         top_fixed_lines <= `LFWS_TFA_RST; // see RULE18
         scroll_region_lines <= `LFWS_VSA_RST;
         bfa <= `LFWS_BFA_RST;
         scrollMode <= 1'b0;
      end else begin
         if (isModeOn) begin
            scrollMode <= 1'b0; // see RULE19
         end
         if (parIn && lowParam) begin
            unique case (state)
               LFWS_PART: begin
                  if (paramIdx == 3'd1) begin
                     sr <= paramWord; // see RULE8
                  end
                  if (paramIdx == 3'd3) begin
                     er <= paramWord;
                  end
               end
               LFWS_SCRDEF: begin
                  if (paramIdx == 3'd1) begin
                     top_fixed_lines <= paramWord; // see RULE12
                  end
                  if (paramIdx == 3'd3) begin
                     scroll_region_lines <= paramWord;
                  end
                  if (paramIdx == 3'd5) begin
                     bfa <= paramWord;
                     scrollMode <= 1'b1;
                  end
               end
               LFWS_MEMWR: begin
               end
               LFWS_IDLE: begin
               end
            endcase
         end
      end
   end

   // line mapping for the refresh side; the low fixed block swaps with the refresh bit
   wire [15:0] lineW = {8'h00, refreshLine};
   wire [15:0] lowFixed = ml ? bfa : top_fixed_lines; // see RULE14
   wire [15:0] scrollEnd = 16'(lowFixed + scroll_region_lines);
   wire inScroll = scrollMode && lineW >= lowFixed && lineW < scrollEnd; // see RULE13
   // offset dips below zero when the low block is large; one fold either way suffices
   wire [15:0] offRaw = 16'(lineW - lowFixed + ssa - lowFixed); // see RULE15
   wire [15:0] offWrap = offRaw[15] ? 16'(offRaw + scroll_region_lines) :
      offRaw >= scroll_region_lines ? 16'(offRaw - scroll_region_lines) : offRaw;
   wire [7:0] next_scrollLine = inScroll ? 8'(lowFixed + offWrap) : refreshLine;
   wire next_partialHit = sr <= er ? (lineW >= sr && lineW <= er) : // see RULE10
      (lineW >= sr || lineW <= er); // see RULE25

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scrollLine <= 8'h00;
         partialHit <= 1'b0;
      end else begin
         scrollLine <= next_scrollLine;
         partialHit <= next_partialHit; // see RULE9
      end
   end

   // register file
   wire [31:0] ctrlWord = {22'h00_0000, geom, memory_access_control};
   wire [31:0] colWord = {ec, sc};
   wire [31:0] pageWord = {ep, sp};
   wire [31:0] ssaWord = {16'h0000, ssa};
   wire [31:0] statusWord = {28'h000_0000, state, scrollMode, state == LFWS_MEMWR};
   wire wrCtrl = wrEn && wrAddr == `LFWS_REG_CTRL;
   wire wrCol = wrEn && wrAddr == `LFWS_REG_WINCOL;
   wire wrPage = wrEn && wrAddr == `LFWS_REG_WINPAGE;
   wire wrSsa = wrEn && wrAddr == `LFWS_REG_SSA;
   wire wrErr = !(wrAddr == `LFWS_REG_CTRL || wrAddr == `LFWS_REG_WINCOL ||
                  wrAddr == `LFWS_REG_WINPAGE || wrAddr == `LFWS_REG_SSA);
   wire [31:0] ctrlNew = merge(ctrlWord, wrData, wrStrb);
   wire [31:0] colNew = merge(colWord, wrData, wrStrb);
   wire [31:0] pageNew = merge(pageWord, wrData, wrStrb);
   wire [31:0] ssaNew = merge(ssaWord, wrData, wrStrb);
   wire [7:0] ra = s_axi_araddr;
   wire rdErr = ra[1:0] != 2'b00 || ra > `LFWS_REG_BFA;
   wire [31:0] rdData =
      ra == `LFWS_REG_CTRL ? ctrlWord :
      ra == `LFWS_REG_WINCOL ? colWord :
      ra == `LFWS_REG_WINPAGE ? pageWord :
      ra == `LFWS_REG_SSA ? ssaWord :
      ra == `LFWS_REG_STATUS ? statusWord :
      ra == `LFWS_REG_PARTIAL ? {er, sr} :
      ra == `LFWS_REG_SCROLL ? {scroll_region_lines, top_fixed_lines} :
      ra == `LFWS_REG_BFA ? {16'h0000, bfa} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         memory_access_control <= `LFWS_MEMORY_ACCESS_CONTROL_RST;
         geom <= `LFWS_GEOM_RST;
         sc <= `LFWS_WIN_START_RST;
         ec <= `LFWS_COL_END_RST;
         sp <= `LFWS_WIN_START_RST;
         ep <= `LFWS_PAGE_END_RST;
         ssa <= `LFWS_SSA_RST;
      end else begin
         if (wrCtrl) begin
            memory_access_control <= ctrlNew[7:0];
            geom <= ctrlNew[9:8];
         end
         if (wrCol) begin
            sc <= colNew[15:0];
            ec <= colNew[31:16];
         end
         if (wrPage) begin
            sp <= pageNew[15:0];
            ep <= pageNew[31:16];
         end
         if (wrSsa) begin
            ssa <= ssaNew[15:0];
         end
      end
   end

   lfws_axil_slave u_axil (
      .clk(clk),
      .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrErr(wrErr),
      .rdData(rdData),
      .rdErr(rdErr)
   );

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_start_reload: assert property ( // see RULE2
      isWrCmd |=> colCnt == $past(colFirst) && pageCnt == $past(pageFirst))
      else $error("counters not reloaded on write command");
   a_pixel_store: assert property ( // see RULE4
      pixelDone && inRange |=> memWrEn && memPixel == $past(pixelWord))
      else $error("pixel not stored");
   a_write_stop: assert property ( // see RULE5
      cmdIn && !isWrCmd |=> state != LFWS_MEMWR ##1 !memWrEn)
      else $error("write not ended by command");
   a_write_keeps_modes: assert property ( // see RULE6
      state == LFWS_MEMWR && parIn |=> $stable(scrollMode) && $stable(sr) && $stable(top_fixed_lines))
      else $error("memory write changed other state");
   a_out_of_range: assert property ( // see RULE23
      pixelDone && !inRange |=> !memWrEn)
      else $error("out of range pixel written");
   a_col_wrap: assert property ( // see RULE24
      pixelDone && colWrap |=> colCnt == $past(colFirst))
      else $error("column did not wrap");
   a_partial_one_row: assert property ( // see RULE10
      sr == er && lineW == sr |=> partialHit)
      else $error("single row partial area missed");
   a_partial_wrap: assert property ( // see RULE25
      er < sr && lineW > er && lineW < sr |=> !partialHit)
      else $error("wrapped partial area wrong");
   a_scroll_exit: assert property ( // see RULE19
      isModeOn && !parIn |=> !scrollMode)
      else $error("scroll mode not left");
   a_fixed_line: assert property ( // see RULE13
      lineW < lowFixed |=> scrollLine == $past(refreshLine))
      else $error("fixed line remapped");
endmodule

// ==== verilog/lfws_map.svh ====
`ifndef LFWS_MAP_SVH
`define LFWS_MAP_SVH
`define LFWS_CMD_MEMWR 8'h2c
`define LFWS_CMD_PARTIAL 8'h30
`define LFWS_CMD_SCROLLDEF 8'h33
`define LFWS_CMD_PARTIAL_ON 8'h12
`define LFWS_CMD_NORMAL_ON 8'h13
`define LFWS_MY_BIT 7
`define LFWS_MX_BIT 6
`define LFWS_MV_BIT 5
`define LFWS_ML_BIT 4
`define LFWS_GEOM_128 2'b01
`define LFWS_GEOM_160 2'b11
`define LFWS_GEOM_RST 2'b11
`define LFWS_MEMORY_ACCESS_CONTROL_RST 8'h00
`define LFWS_MAX_COL 16'h007f
`define LFWS_MAX_ROW_128 16'h007f
`define LFWS_MAX_ROW_160 16'h009f
`define LFWS_SR_RST 16'h0000
`define LFWS_TFA_RST 16'h0000
`define LFWS_VSA_RST 16'h00a0
`define LFWS_BFA_RST 16'h0000
`define LFWS_SSA_RST 16'h0000
`define LFWS_WIN_START_RST 16'h0000
`define LFWS_COL_END_RST 16'h007f
`define LFWS_PAGE_END_RST 16'h009f
`define LFWS_REG_CTRL 8'h00
`define LFWS_REG_WINCOL 8'h04
`define LFWS_REG_WINPAGE 8'h08
`define LFWS_REG_SSA 8'h0c
`define LFWS_REG_STATUS 8'h10
`define LFWS_REG_PARTIAL 8'h14
`define LFWS_REG_SCROLL 8'h18
`define LFWS_REG_BFA 8'h1c
`define LFWS_RESP_OKAY 2'b00
`define LFWS_RESP_SLVERR 2'b10
`endif

// ==== verilog/lfws_pkg.sv ====
package lfws_pkg;
   typedef enum logic [1:0] {
      LFWS_IDLE = 2'b00,
      LFWS_MEMWR = 2'b01,
      LFWS_PART = 2'b11,
      LFWS_SCRDEF = 2'b10
   } lfws_state_t;
endpackage

// ==== verilog/lfws_byte_capture.sv ====
`timescale 1ns/1ps
module lfws_byte_capture
   import lfws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic data_command_select,
   input wire logic write_strobe_n,
   input wire logic [7:0] busData,
   output logic byteValid,
   output logic byteIsCmd,
   output logic [7:0] byteData
);
   logic strobePrev;
   wire strobeRise = write_strobe_n & ~strobePrev;

   // idle-high reset value keeps a strobe held high at release from looking like an edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         strobePrev <= 1'b1;
         byteValid <= 1'b0;
         byteIsCmd <= 1'b0;
         byteData <= 8'h00;
      end else begin
         strobePrev <= write_strobe_n;
         byteValid <= strobeRise; // see RULE1
         if (strobeRise) begin
            byteIsCmd <= ~data_command_select;
            byteData <= busData;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_strobe_latch: assert property ( // see RULE1
      $rose(write_strobe_n) |=> byteValid && byteData == $past(busData))
      else $error("byte not latched on strobe rise");
endmodule

// ==== verilog/lfws_axil_slave.sv ====
`timescale 1ns/1ps
module lfws_axil_slave
   import lfws_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wrEn,
   output logic [7:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrErr,
   input wire logic [31:0] rdData,
   input wire logic rdErr
);
   logic awHeld;
   logic wHeld;
   wire awFire = s_axi_awvalid & s_axi_awready;
   wire wFire = s_axi_wvalid & s_axi_wready;
   wire arFire = s_axi_arvalid & s_axi_arready;
   wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
   wire next_awHeld = (awHeld | awFire) & ~doWrite;
   wire next_wHeld = (wHeld | wFire) & ~doWrite;
   assign wrEn = doWrite;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `LFWS_RESP_OKAY;
         wrAddr <= 8'h00;
         wrData <= 32'h0000_0000;
         wrStrb <= 4'h0;
      end else begin
         awHeld <= next_awHeld;
         wHeld <= next_wHeld;
         s_axi_awready <= ~next_awHeld;
         s_axi_wready <= ~next_wHeld;
         if (awFire) begin
            wrAddr <= s_axi_awaddr;
         end
         if (wFire) begin
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrErr ? `LFWS_RESP_SLVERR : `LFWS_RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `LFWS_RESP_OKAY;
      end else if (arFire) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdData;
         s_axi_rresp <= rdErr ? `LFWS_RESP_SLVERR : `LFWS_RESP_OKAY;
      end else if (!s_axi_rvalid || s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule

// ==== tb/lfws_host_model.sv ====
`timescale 1ns/1ps
module lfws_host_model (
   input wire logic clk,
   output logic data_command_select,
   output logic write_strobe_n,
   output logic [7:0] hostData
);
   initial begin
      data_command_select = 1'b0;
      write_strobe_n = 1'b1;
      hostData = 8'h00;
   end
   // slow stretches the low phase; bus scrambled once the byte is taken
   task automatic send(input logic isData, input logic [7:0] b, input int slow);
      data_command_select <= isData;
      hostData <= b;
      write_strobe_n <= 1'b0;
      repeat (1 + slow) @(posedge clk);
      write_strobe_n <= 1'b1;
      @(posedge clk);
      hostData <= ~b;
      @(posedge clk);
   endtask
endmodule

// ==== tb/lfws_cmd_top_tb_top.sv ====
`timescale 1ns/1ps
module lfws_cmd_top_tb_top
   import lfws_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] refreshLine = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic data_command_select, write_strobe_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, memWrEn, partialHit, scrollMode;
   logic [7:0] hostData, memRow, scrollLine;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [6:0] memColumn;
   logic [17:0] memPixel;
   logic [32:0] wq[$];
   int err_total = 0, total_checks = 0;
   always #2 clk = ~clk;
   always @(posedge clk) if (memWrEn === 1'b1) wq.push_back({memRow, memColumn, memPixel});
   lfws_host_model i_lfws_host_model (.clk, .data_command_select, .write_strobe_n, .hostData);
   lfws_cmd_top i_lfws_cmd_top (.clk, .rst_b, .data_command_select, .write_strobe_n,
      .hostData, .refreshLine, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .memWrEn, .memColumn, .memRow, .memPixel, .scrollLine,
      .partialHit, .scrollMode);
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t %s: got %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic hang;
      err_total++;
      $display("ERROR %0t wait ran out", $time);
      stop_test;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 40) hang;
      chk(s_axi_bresp, er, "bresp");
      @(posedge clk);
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 40) hang;
      chk(s_axi_rresp, er, "rresp");
      if (er == 2'b00) chk(s_axi_rdata, ex, "rdata");
      @(posedge clk);
   endtask
   task automatic cmd(input logic [7:0] b);
      i_lfws_host_model.send(1'b0, b, 0);
   endtask
   task automatic word(input logic [15:0] w);
      i_lfws_host_model.send(1'b1, w[15:8], 1);
      i_lfws_host_model.send(1'b1, w[7:0], 1);
   endtask
   // low two bits of each byte carry nothing
   task automatic pix(input logic [5:0] p);
      i_lfws_host_model.send(1'b1, {p, 2'b11}, 0);
      i_lfws_host_model.send(1'b1, {p + 6'd1, 2'b00}, 0);
      i_lfws_host_model.send(1'b1, {p + 6'd2, 2'b01}, 0);
   endtask
   task automatic look(input logic [7:0] l, input logic [32:0] seenSel, input logic [32:0] e);
      refreshLine <= l;
      repeat (3) @(posedge clk);
      chk(seenSel ? partialHit : scrollLine, e, "refresh");
   endtask
   task automatic t_reset;
      axr(8'h14, 32'h009f_0000, 2'b00);
      axr(8'h18, 32'h00a0_0000, 2'b00);
      axr(8'h24, 32'h0000_0000, 2'b10);
      axw(8'h20, 32'h0000_0001, 2'b10);
      $display("reset values done");
   endtask
   task automatic t_pixels;
      axw(8'h04, 32'h0002_0001, 2'b00);
      axw(8'h08, 32'h0001_0000, 2'b00);
      cmd(8'h2c);
      for (int k = 0; k < 5; k++) pix(6'(k * 8));
      cmd(8'h2c);
      pix(6'd50);
      repeat (3) @(posedge clk);
      chk(wq.size(), 6, "write count");
      for (int k = 0; k < 5; k++)
         chk(wq[k], {8'(k / 2 % 2), 7'(1 + k % 2), 6'(k * 8), 6'(k * 8 + 1), 6'(k * 8 + 2)},
            "pixel");
      chk(wq[5], {8'd0, 7'd1, 6'd50, 6'd51, 6'd52}, "reload");
      axw(8'h00, 32'h0000_0340, 2'b00);
      cmd(8'h2c);
      pix(6'd9);
      repeat (3) @(posedge clk);
      chk(wq[6], {8'd0, 7'd2, 6'd9, 6'd10, 6'd11}, "mirrored start");
      axw(8'h00, 32'h0000_0100, 2'b00);
      axw(8'h08, 32'h0082_0080, 2'b00);
      cmd(8'h2c);
      pix(6'd1);
      repeat (3) @(posedge clk);
      chk(wq.size(), 7, "row beyond geometry");
      axw(8'h00, 32'h0000_0300, 2'b00);
      $display("pixel writes done");
   endtask
   task automatic t_partial;
      wq.delete();
      cmd(8'h2c);
      i_lfws_host_model.send(1'b1, 8'hfc, 0);
      cmd(8'h30);
      word(16'h0005);
      word(16'h0005);
      i_lfws_host_model.send(1'b1, 8'hfc, 0);
      repeat (3) @(posedge clk);
      chk(wq.size(), 0, "write after other command");
      axr(8'h14, 32'h0005_0005, 2'b00);
      look(8'd5, 1, 1'b1);
      look(8'd6, 1, 1'b0);
      cmd(8'h30);
      word(16'h0096);
      word(16'h0002);
      look(8'd155, 1, 1'b1);
      look(8'd100, 1, 1'b0);
      $display("partial area done");
   endtask
   task automatic t_scroll;
      axw(8'h04, 32'h007f_0000, 2'b00);
      axw(8'h08, 32'h009f_0000, 2'b00);
      for (int i = 0; i < 2; i++) begin
         cmd(8'h33);
         word(16'h0000);
         word(16'h0090);
         word(16'h0010);
         repeat (2) @(posedge clk);
         chk(scrollMode, 1'b1, "scroll on");
         axr(8'h18, 32'h0090_0000, 2'b00);
         axw(8'h0c, 32'h0000_0004, 2'b00);
         axw(8'h00, i == 0 ? 32'h0000_0300 : 32'h0000_0310, 2'b00);
         look(8'd20, 0, i == 0 ? 8'd24 : 8'd152);
         if (i == 1) look(8'd5, 0, 8'd5);
         cmd(8'h2c);
         pix(6'd3);
         chk(scrollMode, 1'b1, "scroll kept");
         cmd(i == 0 ? 8'h13 : 8'h12);
         repeat (2) @(posedge clk);
         chk(scrollMode, 1'b0, "scroll off");
      end
      $display("scroll done");
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset;
      t_pixels;
      t_partial;
      t_scroll;
      stop_test;
   end
endmodule
